// *** shared/frc_regs.vh ***
// Purpose: register map, field positions, reset values and command codes
//          of the flash rewrite control block
// Assumes: 8-bit register port, one register per address
// Notes:   definitions only
`ifndef FRC_REGS_VH
`define FRC_REGS_VH

// =====================================================================
// register offsets
`define FRC_OFS_CTRL_STATUS_0    4'h0
`define FRC_OFS_CTRL_1           4'h1
`define FRC_OFS_READ_POWER       4'h2
`define FRC_OFS_MODE_SELECT      4'h3

// =====================================================================
// flash_control_status_0 fields
`define FRC_BIT_READY            0
`define FRC_BIT_REWRITE_ENABLE   1
`define FRC_BIT_LOCK_DISABLE     2
`define FRC_BIT_FLASH_STOP       3
`define FRC_BIT_PROGRAM_ERROR    6
`define FRC_BIT_ERASE_ERROR      7

// flash_control_1 fields
`define FRC_BIT_MODE_REG_WE      1
`define FRC_BIT_LOCK_RESULT      6
`define FRC_BIT_DF_WAIT          7

// flash_read_power_control fields
`define FRC_BIT_SLOW_READ        2
`define FRC_BIT_LOW_CURRENT      3

// flash_erase_write_mode_select fields
`define FRC_BIT_MODE_SELECT      0

// =====================================================================
// reset values
`define FRC_RST_CTRL_BIT         1'b0
`define FRC_RST_LOCK_BIT         1'b1
`define FRC_RST_RDATA            8'h00

// =====================================================================
// software command codes on cmd_code
`define FRC_CMD_READ_ARRAY       4'h0
`define FRC_CMD_READ_STATUS      4'h1
`define FRC_CMD_CLEAR_STATUS     4'h2
`define FRC_CMD_PROGRAM          4'h3
`define FRC_CMD_BLOCK_ERASE      4'h4
`define FRC_CMD_LOCK_PROGRAM     4'h5
`define FRC_CMD_READ_LOCK        4'h6
`define FRC_CMD_BLANK_CHECK      4'h7

`endif

// *** hw/frc_top.v ***
// Purpose: control and status logic for flash cpu rewrite mode
// Assumes: flash core and command decoder run on clk; nmi, watchdog and
//          sleep inputs come from logic on the same clock
// Notes:   register port: addr, wdata, wr, rd; read data one cycle later
//
// Functional notes
// - rewrite_enable sets only by a write of 0 then 1, back to back.
// - lock_disable sets by 0 then 1, only while rewrite_enable is 1.
// - clear-status command clears program and erase error flags.
// - flash_stop acts only while rewrite_enable is 1; otherwise inert.
// - ready flag 0 while a long command executes, 1 otherwise.
// - commands accepted only while rewrite_enable is 1.
// - lock_disable 1 ignores block locks without altering stored state.
// - erase under lock_disable unlocks the erased block on completion without core_fail.
// - flash_stop resets the core, minimises power, blocks all access.
// - stop or wait mode powers flash off, exit powers it back on.
// - read-only program error flag is 1 after a program error.
// - read-only erase error flag reports erase error and blank check.
// - mode-select writes take effect only with mode_reg_write_enable set.
// - lock status result is 1 if block unlocked, 0 if locked.
// - data_flash_wait_select adds a wait state to data-flash access.
// - low-current read acts only while slow read is enabled.
// - with rewrite enabled, mode select 1 picks mode b, 0 mode a.
// - nmi or watchdog resets control registers 0 and 1 and aborts the operation.
// - mode select takes 1 only once rewrite_enable is already 1.
`include "frc_regs.vh"

module frc_top #(
    parameter NBLK = 16,
    parameter BW   = 4
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire [3:0]    reg_addr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [7:0]    reg_rdata,
    input  wire          cmd_valid,
    input  wire [3:0]    cmd_code,
    input  wire [BW-1:0] cmd_block,
    input  wire          core_done,
    input  wire          core_fail,
    input  wire          nmi_event,
    input  wire          wdt_event,
    input  wire          sleep_req,
    output reg           core_start,
    output reg  [3:0]    core_op,
    output reg  [BW-1:0] core_block,
    output reg           core_abort,
    output reg           core_reset,
    output reg           flash_power_off,
    output reg           flash_access_block,
    output reg           lock_override,
    output reg           cmd_refused,
    output reg           erase_write_mode_a,
    output reg           erase_write_mode_b,
    output reg           data_flash_wait,
    output reg           slow_read_active,
    output reg           low_current_active
);

    // =================================================================
    // state machine codes
    localparam [1:0] S_IDLE = 2'b01;
    localparam [1:0] S_BUSY = 2'b10;

    reg  [1:0]      state;
    reg  [1:0]      next_state;
    reg             rewrite_enable;
    reg             lock_disable;
    reg             flash_stop;
    reg             program_error_flag;
    reg             erase_error_flag;
    reg             mode_reg_write_enable;
    reg             lock_status_result;
    reg             data_flash_wait_select;
    reg             slow_read_enable;
    reg             low_current_read_enable;
    reg             erase_write_mode_select;
    reg             re_armed;
    reg             ld_armed;
    reg             cur_lock_dis;
    reg  [NBLK-1:0] lock_bits;

    wire            force_rst;
    wire            wr0;
    wire            wr1;
    wire            wr2;
    wire            wr3;
    wire            stop_eff;
    wire            cmd_ok;
    wire            long_cmd;
    wire            blk_locked;
    wire            prot_refuse;
    wire            go_busy;
    wire            done_ev;
    wire            clr_status;
    wire            set_perr;
    wire            set_eerr;

    // =================================================================
    // decode
    assign force_rst = nmi_event | wdt_event;
    assign wr0       = reg_wr & (reg_addr == `FRC_OFS_CTRL_STATUS_0);
    assign wr1       = reg_wr & (reg_addr == `FRC_OFS_CTRL_1);
    assign wr2       = reg_wr & (reg_addr == `FRC_OFS_READ_POWER);
    assign wr3       = reg_wr & (reg_addr == `FRC_OFS_MODE_SELECT);
    assign stop_eff  = flash_stop & rewrite_enable;

    // =================================================================
    // command acceptance
    assign cmd_ok = cmd_valid & rewrite_enable & ~stop_eff & (state == S_IDLE);
    assign long_cmd = (cmd_code == `FRC_CMD_PROGRAM) | (cmd_code == `FRC_CMD_BLOCK_ERASE) |
                      (cmd_code == `FRC_CMD_LOCK_PROGRAM) | (cmd_code == `FRC_CMD_READ_LOCK) |
                      (cmd_code == `FRC_CMD_BLANK_CHECK);
    assign blk_locked  = ~lock_bits[cmd_block] & ~lock_disable;
    assign prot_refuse = cmd_ok & blk_locked &
                         ((cmd_code == `FRC_CMD_PROGRAM) | (cmd_code == `FRC_CMD_BLOCK_ERASE));
    assign go_busy     = cmd_ok & long_cmd & ~prot_refuse;
    assign done_ev     = (state == S_BUSY) & core_done & ~force_rst;
    assign clr_status  = cmd_ok & (cmd_code == `FRC_CMD_CLEAR_STATUS);
    assign set_perr    = (done_ev & (core_op == `FRC_CMD_PROGRAM) & core_fail) |
                         (prot_refuse & (cmd_code == `FRC_CMD_PROGRAM));
    assign set_eerr    = (done_ev & core_fail & ((core_op == `FRC_CMD_BLOCK_ERASE) |
                         (core_op == `FRC_CMD_BLANK_CHECK))) |
                         (prot_refuse & (cmd_code == `FRC_CMD_BLOCK_ERASE));

    // =================================================================
    // busy state machine
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (go_busy) begin
                    next_state = S_BUSY;
                end
            end
            S_BUSY: begin
                if (force_rst | core_done) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state        <= S_IDLE;
            core_start   <= 1'b0;
            core_op      <= `FRC_CMD_READ_ARRAY;
            core_block   <= {BW{1'b0}};
            core_abort   <= 1'b0;
            cmd_refused  <= 1'b0;
            cur_lock_dis <= 1'b0;
        end else begin
            state       <= next_state;
            core_start  <= go_busy & ~force_rst;
            core_abort  <= force_rst & (state == S_BUSY);
            cmd_refused <= cmd_valid & ~cmd_ok;
            if (go_busy) begin
                core_op      <= cmd_code;
                core_block   <= cmd_block;
                cur_lock_dis <= lock_disable;
            end
        end
    end

    // =================================================================
    // control and status register 0
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rewrite_enable     <= `FRC_RST_CTRL_BIT;
            lock_disable       <= `FRC_RST_CTRL_BIT;
            flash_stop         <= `FRC_RST_CTRL_BIT;
            program_error_flag <= `FRC_RST_CTRL_BIT;
            erase_error_flag   <= `FRC_RST_CTRL_BIT;
            re_armed           <= 1'b0;
            ld_armed           <= 1'b0;
        end else if (force_rst) begin
            rewrite_enable     <= `FRC_RST_CTRL_BIT;
            lock_disable       <= `FRC_RST_CTRL_BIT;
            flash_stop         <= `FRC_RST_CTRL_BIT;
            program_error_flag <= `FRC_RST_CTRL_BIT;
            erase_error_flag   <= `FRC_RST_CTRL_BIT;
            re_armed           <= 1'b0;
            ld_armed           <= 1'b0;
        end else begin
            if (wr0) begin
                if (!reg_wdata[`FRC_BIT_REWRITE_ENABLE]) begin
                    rewrite_enable <= 1'b0;
                end else if (re_armed) begin
                    rewrite_enable <= 1'b1;
                end
                if (!reg_wdata[`FRC_BIT_LOCK_DISABLE]) begin
                    lock_disable <= 1'b0;
                end else if (ld_armed & rewrite_enable) begin
                    lock_disable <= 1'b1;
                end
                flash_stop <= reg_wdata[`FRC_BIT_FLASH_STOP];
            end
            // any register write breaks a pending 0-then-1 pair
            re_armed <= reg_wr ? (wr0 & ~reg_wdata[`FRC_BIT_REWRITE_ENABLE]) : re_armed;
            ld_armed <= reg_wr ? (wr0 & ~reg_wdata[`FRC_BIT_LOCK_DISABLE]) : ld_armed;
            if (set_perr) begin
                program_error_flag <= 1'b1;
            end else if (clr_status) begin
                program_error_flag <= 1'b0;
            end
            if (set_eerr) begin
                erase_error_flag <= 1'b1;
            end else if (clr_status) begin
                erase_error_flag <= 1'b0;
            end
        end
    end

    // =================================================================
    // control register 1
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg_write_enable  <= `FRC_RST_CTRL_BIT;
            data_flash_wait_select <= `FRC_RST_CTRL_BIT;
            lock_status_result     <= `FRC_RST_CTRL_BIT;
        end else if (force_rst) begin
            mode_reg_write_enable  <= `FRC_RST_CTRL_BIT;
            data_flash_wait_select <= `FRC_RST_CTRL_BIT;
            lock_status_result     <= `FRC_RST_CTRL_BIT;
        end else begin
            if (wr1) begin
                mode_reg_write_enable  <= reg_wdata[`FRC_BIT_MODE_REG_WE];
                data_flash_wait_select <= reg_wdata[`FRC_BIT_DF_WAIT];
            end
            if (done_ev & (core_op == `FRC_CMD_READ_LOCK)) begin
                lock_status_result <= lock_bits[core_block];
            end
        end
    end

    // =================================================================
    // read power and mode select registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_read_enable        <= `FRC_RST_CTRL_BIT;
            low_current_read_enable <= `FRC_RST_CTRL_BIT;
            erase_write_mode_select <= `FRC_RST_CTRL_BIT;
        end else begin
            if (wr2) begin
                slow_read_enable        <= reg_wdata[`FRC_BIT_SLOW_READ];
                low_current_read_enable <= reg_wdata[`FRC_BIT_LOW_CURRENT];
            end
            if (wr3 & mode_reg_write_enable) begin
                erase_write_mode_select <= reg_wdata[`FRC_BIT_MODE_SELECT] &
                                           rewrite_enable;
            end
        end
    end

    // =================================================================
    // per-block lock bits
    genvar gi;
    generate
        for (gi = 0; gi < NBLK; gi = gi + 1) begin : g_lock
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    lock_bits[gi] <= `FRC_RST_LOCK_BIT;
                end else if (done_ev && (core_block == gi)) begin
                    if (core_op == `FRC_CMD_LOCK_PROGRAM && !core_fail) begin
                        lock_bits[gi] <= 1'b0;
                    end else if (core_op == `FRC_CMD_BLOCK_ERASE && cur_lock_dis &&
                                 !core_fail) begin
                        lock_bits[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // =================================================================
    // registered outputs to the flash array
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset         <= 1'b0;
            flash_power_off    <= 1'b0;
            flash_access_block <= 1'b0;
            lock_override      <= 1'b0;
            erase_write_mode_a <= 1'b0;
            erase_write_mode_b <= 1'b0;
            data_flash_wait    <= 1'b0;
            slow_read_active   <= 1'b0;
            low_current_active <= 1'b0;
        end else begin
            core_reset         <= stop_eff;
            flash_power_off    <= stop_eff | sleep_req;
            flash_access_block <= stop_eff | sleep_req;
            lock_override      <= lock_disable;
            erase_write_mode_a <= rewrite_enable & ~erase_write_mode_select;
            erase_write_mode_b <= rewrite_enable & erase_write_mode_select;
            data_flash_wait    <= data_flash_wait_select;
            slow_read_active   <= slow_read_enable;
            low_current_active <= low_current_read_enable & slow_read_enable;
        end
    end

    // =================================================================
    // register read port
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `FRC_RST_RDATA;
        end else begin
            reg_rdata <= `FRC_RST_RDATA;
            if (reg_rd) begin
                case (reg_addr)
                    `FRC_OFS_CTRL_STATUS_0: begin
                        reg_rdata[`FRC_BIT_READY]          <= (state == S_IDLE);
                        reg_rdata[`FRC_BIT_REWRITE_ENABLE] <= rewrite_enable;
                        reg_rdata[`FRC_BIT_LOCK_DISABLE]   <= lock_disable;
                        reg_rdata[`FRC_BIT_FLASH_STOP]     <= flash_stop;
                        reg_rdata[`FRC_BIT_PROGRAM_ERROR]  <= program_error_flag;
                        reg_rdata[`FRC_BIT_ERASE_ERROR]    <= erase_error_flag;
                    end
                    `FRC_OFS_CTRL_1: begin
                        reg_rdata[`FRC_BIT_MODE_REG_WE] <= mode_reg_write_enable;
                        reg_rdata[`FRC_BIT_LOCK_RESULT] <= lock_status_result;
                        reg_rdata[`FRC_BIT_DF_WAIT]     <= data_flash_wait_select;
                    end
                    `FRC_OFS_READ_POWER: begin
                        reg_rdata[`FRC_BIT_SLOW_READ]   <= slow_read_enable;
                        reg_rdata[`FRC_BIT_LOW_CURRENT] <= low_current_read_enable;
                    end
                    `FRC_OFS_MODE_SELECT: begin
                        reg_rdata[`FRC_BIT_MODE_SELECT] <= erase_write_mode_select;
                    end
                    default: begin
                        reg_rdata <= `FRC_RST_RDATA;
                    end
                endcase
            end
        end
    end

endmodule // frc_top

// *** verification/frc_top_monitor.sv ***
// Purpose: concurrent checks on the ports of frc_top
// Assumes: one clock, async active-low reset, outputs lag one clk
// Notes:   bound to every frc_top instance
// =====================================================================
// checker
module frc_top_monitor #(
    parameter NBLK = 16,
    parameter BW   = 4
) (
    input logic       clk,
    input logic       arst_n,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       cmd_valid,
    input logic [3:0] cmd_code,
    input logic       nmi_event,
    input logic       wdt_event,
    input logic       sleep_req,
    input logic       core_start,
    input logic [3:0] core_op,
    input logic       core_abort,
    input logic       core_reset,
    input logic       flash_power_off,
    input logic       flash_access_block,
    input logic       lock_override,
    input logic       cmd_refused,
    input logic       erase_write_mode_a,
    input logic       erase_write_mode_b,
    input logic       slow_read_active,
    input logic       low_current_active
);
    timeunit 1ns;
    timeprecision 1ps;
    wire re_out = erase_write_mode_a | erase_write_mode_b;
    wire w0     = reg_wr && (reg_addr == 4'h0);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rewrite_pair: assert property ($rose(re_out) |->
        $past(w0 && reg_wdata[1], 2) && $past(w0 && !reg_wdata[1], 3))
        else $error("rewrite enable set without a 0 then 1 pair");
    a_lock_pair: assert property ($rose(lock_override) |->
        $past(w0 && reg_wdata[2], 2) && $past(w0 && !reg_wdata[2], 3) && $past(re_out))
        else $error("lock disable set without pair or rewrite enable");
    a_stop_gated: assert property (core_reset |-> re_out)
        else $error("flash stop acting with rewrite disabled");
    a_power_off: assert property (
        flash_power_off == (core_reset || $past(sleep_req)) && flash_access_block == flash_power_off)
        else $error("power off or access block wrong");
    a_low_current: assert property (low_current_active |-> slow_read_active)
        else $error("low current read without slow read");
    a_cmd_refuse: assert property (cmd_valid ##1 !re_out |-> cmd_refused && !core_start)
        else $error("command taken with rewrite disabled");
    a_start_cause: assert property (core_start |->
        $past(cmd_valid) && re_out && !core_reset && core_op == $past(cmd_code)
        && $past(cmd_code) >= 4'h3 && $past(cmd_code) <= 4'h7)
        else $error("core start without an accepted long command");
    a_refuse_pulse: assert property (cmd_refused |-> $past(cmd_valid) && !core_start)
        else $error("refusal without command");
    a_event_clear: assert property ((nmi_event || wdt_event) |->
        ##2 !re_out && !lock_override)
        else $error("control registers not cleared by event");
    a_abort_cause: assert property (core_abort |-> $past(nmi_event || wdt_event))
        else $error("abort without event");
    a_mode_excl: assert property (!(erase_write_mode_a && erase_write_mode_b))
        else $error("both erase write modes active");
endmodule // frc_top_monitor

bind frc_top frc_top_monitor #(.NBLK(NBLK), .BW(BW)) i_frc_top_monitor (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .nmi_event(nmi_event),
    .wdt_event(wdt_event), .sleep_req(sleep_req), .core_start(core_start),
    .core_op(core_op), .core_abort(core_abort), .core_reset(core_reset),
    .flash_power_off(flash_power_off), .flash_access_block(flash_access_block),
    .lock_override(lock_override), .cmd_refused(cmd_refused),
    .erase_write_mode_a(erase_write_mode_a), .erase_write_mode_b(erase_write_mode_b),
    .slow_read_active(slow_read_active), .low_current_active(low_current_active));

// *** verification/frc_top_test.sv ***
// Purpose: self-checking bench for frc_top
// Assumes: registers at 0..3, read data one cycle after the read strobe
// Notes:   fixed-seed random commands; bench models flags and lock bits
`include "frc_regs.vh"
module frc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // =================================================================
    // signals
    reg        clk = 1'b0;
    reg        arst_n = 1'b0;
    reg  [3:0] reg_addr = 4'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0;
    reg  [3:0] cmd_code = 4'h0, cmd_block = 4'h0;
    reg        core_done = 1'b0, core_fail = 1'b0, nmi_event = 1'b0;
    reg        wdt_event = 1'b0, sleep_req = 1'b0;
    wire [7:0] reg_rdata;
    wire [3:0] core_op, core_block;
    wire       core_start, core_abort, core_reset, flash_power_off, flash_access_block;
    wire       lock_override, cmd_refused, erase_write_mode_a, erase_write_mode_b;
    wire       data_flash_wait, slow_read_active, low_current_active;
    integer    fails = 0, checked = 0, seed = 75248, i, n;
    reg [15:0] lock = 16'hffff;
    reg        pe = 1'b0, ee = 1'b0, ld = 1'b0, lr = 1'b0;
    frc_top i_frc_top (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_block(cmd_block), .core_done(core_done),
        .core_fail(core_fail), .nmi_event(nmi_event), .wdt_event(wdt_event),
        .sleep_req(sleep_req), .core_start(core_start), .core_op(core_op),
        .core_block(core_block), .core_abort(core_abort), .core_reset(core_reset),
        .flash_power_off(flash_power_off), .flash_access_block(flash_access_block),
        .lock_override(lock_override), .cmd_refused(cmd_refused),
        .erase_write_mode_a(erase_write_mode_a), .erase_write_mode_b(erase_write_mode_b),
        .data_flash_wait(data_flash_wait), .slow_read_active(slow_read_active),
        .low_current_active(low_current_active));
    always #2.5 clk = ~clk;
    // =================================================================
    // tasks
    task chk(input [8*16-1:0] name, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, e, g);
            end
        end
    endtask
    task chk1(input [8*16-1:0] name, input e, input g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %b seen %b", name, e, g);
            end
        end
    endtask
    function [7:0] st0(input r);
        st0 = {ee, pe, 3'b000, ld, 1'b1, r};
    endfunction
    task wr(input [3:0] a, input [7:0] d);
        begin
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge clk);
        end
    endtask
    task rd(input [3:0] a, input [7:0] e, input [8*16-1:0] name);
        begin
            reg_wr   <= 1'b0;
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(name, e, reg_rdata);
        end
    endtask
    task idle;
        begin
            reg_wr <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task cmd(input [3:0] c, input [3:0] b, input st, input rf);
        begin
            reg_wr    <= 1'b0;
            cmd_valid <= 1'b1;
            cmd_code  <= c;
            cmd_block <= b;
            @(posedge clk);
            cmd_valid <= 1'b0;
            #1 chk1("core_start", st, core_start);
            chk1("cmd_refused", rf, cmd_refused);
        end
    endtask
    task run(input integer cnt);
        integer   k;
        reg [3:0] c, b;
        reg       f, go;
        begin
            for (k = 0; k < cnt; k = k + 1) begin
                c  = {$random(seed)} % 8;
                b  = {2'b00, 2'($random(seed))};
                f  = $random(seed);
                go = (c > 4'h2) && !((c == 4'h3 || c == 4'h4) && !lock[b] && !ld);
                if (c == 4'h5 || c == 4'h6 || (c == 4'h4 && ld)) f = 1'b0;
                cmd(c, b, go, 1'b0);
                if (go) begin
                    chk("core_block", b, core_block);
                    rd(4'h0, st0(1'b0), "busy_status");
                    n = 1 + {$random(seed)} % 4;
                    repeat (n) @(posedge clk);
                    core_done <= 1'b1;
                    core_fail <= f;
                    @(posedge clk);
                    core_done <= 1'b0;
                    if (c == 4'h3 && f) pe = 1'b1;
                    if ((c == 4'h4 || c == 4'h7) && f) ee = 1'b1;
                    if (c == 4'h4 && ld) lock[b] = 1'b1;
                    if (c == 4'h5) lock[b] = 1'b0;
                    if (c == 4'h6) lr = lock[b];
                end else if (c == 4'h2) begin
                    pe = 1'b0;
                    ee = 1'b0;
                end else if (c == 4'h3) pe = 1'b1;
                else if (c == 4'h4) ee = 1'b1;
                rd(4'h0, st0(1'b1), "status");
                rd(4'h1, {1'b1, lr, 6'b000010}, "ctrl_1");
            end
        end
    endtask
    task end_of_test;
        begin
            if (fails == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // =================================================================
    // sequence
    initial begin
        #200000;
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 4; i = i + 1) rd(i[3:0], {7'h00, i == 0}, "reset_value");
        rd(4'h9, 8'h00, "unmapped");
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h01, "lone_one");
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h01, "broken_pair");
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h04);
        rd(4'h0, 8'h01, "lock_no_rewrite");
        wr(4'h1, 8'h02);
        wr(4'h3, 8'h01);
        rd(4'h3, 8'h00, "early_select");
        wr(4'h0, 8'h08);
        rd(4'h0, 8'h09, "stop_stored");
        chk1("core_reset", 1'b0, core_reset);
        cmd(4'h3, 4'h0, 1'b0, 1'b1);
        wr(4'h2, 8'h08);
        idle;
        chk1("low_current", 1'b0, low_current_active);
        wr(4'h2, 8'h04);
        wr(4'h2, 8'h0c);
        idle;
        chk1("low_current", 1'b1, low_current_active);
        chk1("slow_read", 1'b1, slow_read_active);
        wr(4'h2, 8'h04);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h02);
        idle;
        chk1("mode_a", 1'b1, erase_write_mode_a);
        rd(4'h0, 8'h03, "rewrite_on");
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h01);
        rd(4'h3, 8'h00, "select_locked");
        wr(4'h1, 8'h82);
        wr(4'h3, 8'h01);
        idle;
        chk1("mode_b", 1'b1, erase_write_mode_b);
        chk1("df_wait", 1'b1, data_flash_wait);
        run(24);
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h06);
        ld = 1'b1;
        idle;
        chk1("lock_override", 1'b1, lock_override);
        run(24);
        wr(4'h0, 8'h0e);
        idle;
        chk1("core_reset", 1'b1, core_reset);
        chk1("access_block", 1'b1, flash_access_block);
        cmd(4'h7, 4'h0, 1'b0, 1'b1);
        wr(4'h0, 8'h06);
        idle;
        sleep_req <= 1'b1;
        idle;
        chk1("power_off", 1'b1, flash_power_off);
        sleep_req <= 1'b0;
        idle;
        chk1("power_off", 1'b0, flash_power_off);
        cmd(4'h2, 4'h0, 1'b0, 1'b0);
        for (i = 0; i < 2; i = i + 1) begin
            wr(4'h0, 8'h00);
            wr(4'h0, 8'h02);
            rd(4'h0, 8'h03, "rewrite_on");
            cmd(4'h6, 4'h0, 1'b1, 1'b0);
            nmi_event <= (i == 0);
            wdt_event <= (i == 1);
            @(posedge clk);
            nmi_event <= 1'b0;
            wdt_event <= 1'b0;
            #1 chk1("core_abort", 1'b1, core_abort);
            rd(4'h0, 8'h01, "event_ctl0");
            rd(4'h1, 8'h00, "event_ctl1");
        end
        end_of_test;
    end
endmodule // frc_top_test
